// ===== dv/cark_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cark_host_model (
  // register port
  input wire logic i_core_clk,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_rd,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  // idle data carries the complement of the last byte, not the last value
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
    // registers take the byte at the edge above; let it settle
    @(posedge i_core_clk);
  endtask : wr
  // answer taken at the edge where the valid flag is seen high
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    @(posedge i_core_clk);
    while (i_rvalid !== 1'b1) @(posedge i_core_clk);
    d = i_rdata;
  endtask : rd
endmodule : cark_host_model
`default_nettype wire

// ===== dv/cark_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
module cark_regs_sva
  import cark_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_conv_global_en,
  input wire logic i_soft_reg_reset,
  input wire logic [cark_pkg::CARK_NCHAN-1:0] o_chan_convert_en,
  input wire logic [1:0] o_boost_high_side_strength,
  input wire logic [1:0] o_buck_high_side_strength,
  input wire logic [1:0] o_boost_low_side_strength,
  input wire logic [1:0] o_buck_low_side_strength
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] drv;
  assign drv = {o_boost_high_side_strength, o_buck_high_side_strength,
                o_boost_low_side_strength, o_buck_low_side_strength};
  property p_rvalid; i_rd |=> o_rvalid ##1 !o_rvalid || $past(i_rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer late");
  property p_hold; !i_rd |=> $stable(o_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_gate; i_wr && i_addr == 8'h3B && !i_soft_reg_reset |=> drv == $past(i_wdata);
  endproperty
  a_gate: assert property (p_gate) else $error("strength fields wrong");
  property p_gate_rd; i_rd && i_addr == 8'h3B |=> o_rdata == $past(drv); endproperty
  a_gate_rd: assert property (p_gate_rd) else $error("strength readback wrong");
  property p_chan; i_wr && i_addr == 8'h2C && !i_soft_reg_reset |=> o_chan_convert_en ==
    ({6{i_conv_global_en}} & ~$past({i_wdata[1], i_wdata[2], i_wdata[4], i_wdata[5],
    i_wdata[6], i_wdata[7]}));
  endproperty
  a_chan: assert property (p_chan) else $error("channel enable wrong");
  property p_glob; !i_conv_global_en |-> o_chan_convert_en == 6'h00; endproperty
  a_glob: assert property (p_glob) else $error("converts while off");
  property p_soft; i_soft_reg_reset |=> drv == 8'h00 &&
    o_chan_convert_en == {1'b0, {5{i_conv_global_en}}}; endproperty
  a_soft: assert property (p_soft) else $error("soft reset missed");
  property p_resv; i_rd && i_addr == 8'h2C |=> o_rdata[3] && !o_rdata[0]; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits wrong");
  c_gate: cover property (i_wr && i_addr == 8'h3B);
  c_soft: cover property (i_soft_reg_reset);
  c_res: cover property (i_rd && i_addr == 8'h2E);
endmodule : cark_regs_sva
bind cark_regs cark_regs_sva u_sva (.*);
`default_nettype wire

// ===== dv/tb_cark_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_cark_regs;
  import cark_pkg::*;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_wr, i_rd, o_rvalid, i_conv_global_en = 1'b1;
  logic i_soft_reg_reset = 1'b0;
  logic [7:0] i_addr, i_wdata, o_rdata, d;
  logic [5:0] i_sample_valid = 6'h00, o_chan_convert_en;
  logic [95:0] i_sample_data = '0;
  logic [1:0] bh, kh, bl, kl;
  logic [15:0] v;
  int n_fail = 0, comparisons = 0, cyc = 0;
  logic [7:0] base [6] = '{8'h2D, 8'h2F, 8'h31, 8'h33, 8'h37, 8'h39};
  int ch [10] = '{0, 0, 0, 1, 1, 2, 3, 4, 5, 5};
  logic [15:0] raw [10] = '{16'h8000, 16'h7000, 16'hF000, 16'h8000, 16'h7000,
                            16'hFFFF, 16'h1234, 16'h0500, 16'h0900, 16'h07FF};
  logic [15:0] exp [10] = '{16'h9E58, 16'h61A8, 16'hF000, 16'hD8F0, 16'h2710,
                            16'h0000, 16'h1234, 16'h03FF, 16'h07FF, 16'h07FF};
  always #20 i_core_clk = ~i_core_clk;
  cark_host_model host (.i_core_clk(i_core_clk), .o_addr(i_addr), .o_wr(i_wr),
    .o_wdata(i_wdata), .o_rd(i_rd), .i_rdata(o_rdata), .i_rvalid(o_rvalid));
  cark_regs dut (.i_core_clk, .i_rst, .i_addr, .i_wr, .i_wdata, .i_rd, .o_rdata,
    .o_rvalid, .i_conv_global_en, .i_soft_reg_reset, .i_sample_valid, .i_sample_data,
    .o_chan_convert_en, .o_boost_high_side_strength(bh), .o_buck_high_side_strength(kh),
    .o_boost_low_side_strength(bl), .o_buck_low_side_strength(kl));
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    comparisons++;
    if (got !== want) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk
  task automatic rd16(input int c);
    host.rd(base[c], v[7:0]);
    host.rd(base[c] + 8'h01, v[15:8]);
  endtask : rd16
  task automatic samp(input int c, input logic [15:0] r);
    @(posedge i_core_clk);
    i_sample_valid <= 6'h01 << c;
    i_sample_data[c*16 +: 16] <= r;
    @(posedge i_core_clk);
    i_sample_valid <= 6'h00;
  endtask : samp
  task automatic conclude();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // bounded run, a hang counts as a mismatch
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    host.rd(8'h2C, d); chk(d, 8'h0A);
    host.rd(8'h3B, d); chk(d, 8'h00);
    host.wr(8'h3B, 8'hE4); chk({bh, kh, bl, kl}, 8'hE4);
    host.wr(8'h3B, 8'h1B); host.rd(8'h3B, d); chk(d, 8'h1B);
    host.wr(8'h2C, 8'h00); host.rd(8'h2C, d); chk(d, 8'h08);
    chk(o_chan_convert_en, 6'h3F);
    for (int k = 0; k < 10; k++) begin
      samp(ch[k], raw[k]);
      rd16(ch[k]); chk(v, exp[k]);
    end
    host.wr(8'h2C, 8'h80); chk(o_chan_convert_en, 6'h3E);
    samp(0, 16'h0100); rd16(0); chk(v, 16'hF000);
    host.wr(8'h2C, 8'h62); chk(o_chan_convert_en, 6'h19);
    host.rd(8'h2C, d); chk(d, 8'h6A);
    host.wr(8'h2C, 8'h00);
    i_conv_global_en <= 1'b0;
    samp(0, 16'h0100); chk(o_chan_convert_en, 6'h00);
    rd16(0); chk(v, 16'hF000);
    i_conv_global_en <= 1'b1;
    host.wr(8'h2D, 8'h55); host.rd(8'h2D, d); chk(d, 8'h00);
    host.rd(8'h3C, d); chk(d, 8'h00);
    host.wr(8'h3B, 8'hFF);
    @(posedge i_core_clk) i_soft_reg_reset <= 1'b1;
    @(posedge i_core_clk) i_soft_reg_reset <= 1'b0;
    host.rd(8'h2C, d); chk(d, 8'h0A);
    host.rd(8'h3B, d); chk(d, 8'h00);
    conclude();
  end
endmodule : tb_cark_regs
`default_nettype wire

// ===== pkg/cark_pkg.sv
package cark_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CARK_ADDR_CHAN_DIS = 8'h2C;
  localparam logic [7:0] CARK_ADDR_IN_CUR = 8'h2D;
  localparam logic [7:0] CARK_ADDR_BAT_CUR = 8'h2F;
  localparam logic [7:0] CARK_ADDR_IN_VOLT = 8'h31;
  localparam logic [7:0] CARK_ADDR_BAT_VOLT = 8'h33;
  localparam logic [7:0] CARK_ADDR_THERM = 8'h37;
  localparam logic [7:0] CARK_ADDR_FB = 8'h39;
  localparam logic [7:0] CARK_ADDR_GATE_DRV = 8'h3B;
  // ---------------------------------------------------------------
  // reset values and field masks
  // ---------------------------------------------------------------
  localparam logic [7:0] CARK_RST_CHAN_DIS = 8'h0A;
  localparam logic [7:0] CARK_RST_GATE_DRV = 8'h00;
  localparam logic [7:0] CARK_MASK_CHAN_DIS = 8'hF6;
  localparam int CARK_BIT_IN_CUR = 7;
  localparam int CARK_BIT_BAT_CUR = 6;
  localparam int CARK_BIT_IN_VOLT = 5;
  localparam int CARK_BIT_BAT_VOLT = 4;
  localparam int CARK_BIT_THERM = 2;
  localparam int CARK_BIT_FB = 1;
  localparam int CARK_LSB_BOOST_HS = 6;
  localparam int CARK_LSB_BUCK_HS = 4;
  localparam int CARK_LSB_BOOST_LS = 2;
  localparam int CARK_LSB_BUCK_LS = 0;
  // ---------------------------------------------------------------
  // clamp limits
  // ---------------------------------------------------------------
  localparam logic [15:0] CARK_IN_CUR_MIN = 16'h9E58;
  localparam logic [15:0] CARK_IN_CUR_MAX = 16'h61A8;
  localparam logic [15:0] CARK_BAT_CUR_MIN = 16'hD8F0;
  localparam logic [15:0] CARK_BAT_CUR_MAX = 16'h2710;
  localparam logic [15:0] CARK_VOLT_MAX = 16'h7FFF;
  localparam logic [15:0] CARK_THERM_MAX = 16'h03FF;
  localparam logic [15:0] CARK_FB_MAX = 16'h07FF;
  localparam int CARK_NCHAN = 6;

  typedef enum logic [1:0] {
    CARK_CLAMP_SIGNED,
    CARK_CLAMP_LOW,
    CARK_CLAMP_HIGH
  } cark_clamp_e;
endpackage : cark_pkg

// ===== pkg/cark_res_if.sv
`timescale 1ns/100ps
`default_nettype none
// per-channel raw sample in, clamped result out
interface cark_res_if;
  logic [15:0] raw;
  logic strobe;
  logic [15:0] value;
  modport owner (output raw, output strobe, input value);
  modport fmt (input raw, input strobe, output value);
endinterface : cark_res_if
`default_nettype wire

// ===== rtl/cark_regs.sv
`timescale 1ns/100ps
`default_nettype none
//
// Function
// RULE1: disable bits gate each channel's conversion
// RULE2: host should disable battery current under load
// RULE3: host should disable feedback while charging
// RULE4: results read as low then high byte
// RULE5: input current signed, clamped 9E58h..61A8h
// RULE6: battery current signed, clamped D8F0h..2710h
// RULE7: voltages clamped low, 0h..7FFFh
// RULE8: thermistor clamped high at 3FFh
// RULE9: feedback clamped high at 7FFh
// RULE10: four two-bit gate drive strength fields
// RULE11: global enable required for any conversion
// RULE12: soft reset restores controls; results read-only
//
module cark_regs
  import cark_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // register port from serial interface decoder
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // control from elsewhere in the device
  input wire logic i_conv_global_en,
  input wire logic i_soft_reg_reset,
  // converter samples, order: in_cur, bat_cur, in_volt, bat_volt, therm, fb
  input wire logic [cark_pkg::CARK_NCHAN-1:0] i_sample_valid,
  input wire logic [cark_pkg::CARK_NCHAN*16-1:0] i_sample_data,
  // to converter and power stage
  output logic [cark_pkg::CARK_NCHAN-1:0] o_chan_convert_en,
  output logic [1:0] o_boost_high_side_strength,
  output logic [1:0] o_buck_high_side_strength,
  output logic [1:0] o_boost_low_side_strength,
  output logic [1:0] o_buck_low_side_strength
);
  import cark_pkg::*;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  // results and unmapped bytes have no hit, so writes to them
  // are dropped without touching any state
  logic wr_chan_dis_hit;
  logic wr_gate_drv_hit;
  assign wr_chan_dis_hit = i_wr && (i_addr == CARK_ADDR_CHAN_DIS);
  assign wr_gate_drv_hit = i_wr && (i_addr == CARK_ADDR_GATE_DRV); // RULE12

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // only the writable bits of the channel register take host data
  localparam logic [7:0] CHAN_DIS_KEEP = CARK_RST_CHAN_DIS & ~CARK_MASK_CHAN_DIS;
  logic [7:0] chan_dis_q;
  logic [7:0] chan_dis_d;
  logic [7:0] gate_drv_q;
  logic [7:0] gate_drv_d;

  always_comb begin
    chan_dis_d = chan_dis_q;
    gate_drv_d = gate_drv_q;
    // soft reset wins over a write in the same cycle
    if (i_soft_reg_reset) begin
      chan_dis_d = CARK_RST_CHAN_DIS; // RULE12
      gate_drv_d = CARK_RST_GATE_DRV; // RULE12
    end else begin
      // reserved bits 3 and 0 hold their reset level
      if (wr_chan_dis_hit) begin
        chan_dis_d = (i_wdata & CARK_MASK_CHAN_DIS) | CHAN_DIS_KEEP; // RULE1
      end
      if (wr_gate_drv_hit) begin
        gate_drv_d = i_wdata; // RULE10
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      chan_dis_q <= CARK_RST_CHAN_DIS;
      gate_drv_q <= CARK_RST_GATE_DRV;
    end else begin
      chan_dis_q <= chan_dis_d;
      gate_drv_q <= gate_drv_d;
    end
  end

  // ---------------------------------------------------------------
  // channel enables
  // ---------------------------------------------------------------
  // register bit of each channel's off flag, in channel order
  localparam int OFF_BIT [CARK_NCHAN] = '{CARK_BIT_IN_CUR, CARK_BIT_BAT_CUR,
      CARK_BIT_IN_VOLT, CARK_BIT_BAT_VOLT, CARK_BIT_THERM, CARK_BIT_FB};
  // one bit per channel, filled in the per-channel loop below
  wire logic [CARK_NCHAN-1:0] dis_vec;
  // advised off-states under load or charging are left to the host;
  // forcing them here would make the register disagree with the hardware
  assign o_chan_convert_en = {CARK_NCHAN{i_conv_global_en}} & ~dis_vec; // RULE1 RULE11

  // ---------------------------------------------------------------
  // sample accept
  // ---------------------------------------------------------------
  // a sample only lands when its channel is enabled at that edge
  logic [CARK_NCHAN-1:0] sample_take;
  assign sample_take = i_sample_valid & o_chan_convert_en; // RULE1 RULE11

  // ---------------------------------------------------------------
  // gate drive strength
  // ---------------------------------------------------------------
  assign o_boost_high_side_strength = gate_drv_q[CARK_LSB_BOOST_HS +: 2]; // RULE10
  assign o_buck_high_side_strength = gate_drv_q[CARK_LSB_BUCK_HS +: 2]; // RULE10
  assign o_boost_low_side_strength = gate_drv_q[CARK_LSB_BOOST_LS +: 2]; // RULE10
  assign o_buck_low_side_strength = gate_drv_q[CARK_LSB_BUCK_LS +: 2]; // RULE10

  // ---------------------------------------------------------------
  // result formatting, one per channel
  // ---------------------------------------------------------------
  // clamp style per channel: currents signed at both ends, voltages
  // floored at zero, thermistor and feedback capped at their top code
  localparam cark_clamp_e MODES [CARK_NCHAN] = '{
      CARK_CLAMP_SIGNED, // input current
      CARK_CLAMP_SIGNED, // battery current
      CARK_CLAMP_LOW, // input voltage
      CARK_CLAMP_LOW, // battery voltage
      CARK_CLAMP_HIGH, // thermistor
      CARK_CLAMP_HIGH // feedback
  };
  // floors, used by the signed channels only
  localparam logic [15:0] LOS [CARK_NCHAN] = '{
      CARK_IN_CUR_MIN,
      CARK_BAT_CUR_MIN,
      16'h0000,
      16'h0000,
      16'h0000,
      16'h0000
  };
  // ceilings; a voltage reaches its ceiling by sign alone
  localparam logic [15:0] HIS [CARK_NCHAN] = '{
      CARK_IN_CUR_MAX,
      CARK_BAT_CUR_MAX,
      CARK_VOLT_MAX,
      CARK_VOLT_MAX,
      CARK_THERM_MAX,
      CARK_FB_MAX
  };

  logic [15:0] result [CARK_NCHAN];

  genvar g;
  generate
    for (g = 0; g < CARK_NCHAN; g++) begin : g_chan
      cark_res_if res ();
      assign dis_vec[g] = chan_dis_q[OFF_BIT[g]]; // RULE1
      assign res.raw = i_sample_data[g*16 +: 16];
      assign res.strobe = sample_take[g]; // RULE1 RULE11
      // one shared clamp block; channels differ only by parameters
      cark_result_fmt #(
        .MODE(MODES[g]),
        .LO(LOS[g]),
        .HI(HIS[g])
      ) u_fmt ( // RULE5 RULE6 RULE7 RULE8 RULE9
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .res(res)
      );
      assign result[g] = res.value;
    end
  endgenerate

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  always_comb begin
    rdata_d = 8'h00;
    rvalid_d = i_rd;
    // results have no write path at all; bytes are read live with no
    // snapshot, so a low and a high byte may come from two samples
    case (i_addr) // RULE4 RULE12
      CARK_ADDR_CHAN_DIS: rdata_d = chan_dis_q;
      CARK_ADDR_IN_CUR: rdata_d = result[0][7:0];
      CARK_ADDR_IN_CUR + 8'h01: rdata_d = result[0][15:8];
      CARK_ADDR_BAT_CUR: rdata_d = result[1][7:0];
      CARK_ADDR_BAT_CUR + 8'h01: rdata_d = result[1][15:8];
      CARK_ADDR_IN_VOLT: rdata_d = result[2][7:0];
      CARK_ADDR_IN_VOLT + 8'h01: rdata_d = result[2][15:8];
      CARK_ADDR_BAT_VOLT: rdata_d = result[3][7:0];
      CARK_ADDR_BAT_VOLT + 8'h01: rdata_d = result[3][15:8];
      CARK_ADDR_THERM: rdata_d = result[4][7:0];
      CARK_ADDR_THERM + 8'h01: rdata_d = result[4][15:8];
      CARK_ADDR_FB: rdata_d = result[5][7:0];
      CARK_ADDR_FB + 8'h01: rdata_d = result[5][15:8];
      CARK_ADDR_GATE_DRV: rdata_d = gate_drv_q;
      default: rdata_d = 8'h00;
    endcase
    if (!i_rd) begin
      rdata_d = rdata_q;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
endmodule : cark_regs
`default_nettype wire

// ===== rtl/cark_result_fmt.sv
`timescale 1ns/100ps
`default_nettype none
module cark_result_fmt
  import cark_pkg::*;
#(
  parameter cark_clamp_e MODE = CARK_CLAMP_SIGNED,
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hFFFF
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // sample path
  cark_res_if.fmt res
);
  logic [15:0] value_q;
  logic [15:0] value_d;
  logic [15:0] clamped;

  always_comb begin
    case (MODE)
      CARK_CLAMP_SIGNED: begin
        if ($signed(res.raw) < $signed(LO)) begin
          clamped = LO;
        end else if ($signed(res.raw) > $signed(HI)) begin
          clamped = HI;
        end else begin
          clamped = res.raw;
        end
      end
      // negative raw codes floor at zero
      CARK_CLAMP_LOW: begin
        clamped = res.raw[15] ? 16'h0000 : res.raw;
      end
      CARK_CLAMP_HIGH: begin
        clamped = (res.raw > HI) ? HI : res.raw;
      end
      default: begin
        clamped = res.raw;
      end
    endcase
    value_d = res.strobe ? clamped : value_q;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      value_q <= 16'h0000;
    end else begin
      value_q <= value_d;
    end
  end

  assign res.value = value_q;
endmodule : cark_result_fmt
`default_nettype wire
